// file: smbus_register_slave.sv
// Purpose: Serial management bus slave reaching internal registers via a pointer.
// Assumes: scl_in and sda_in are already synchronous to clock.
// Notes: Open-drain data: sda_oe high pulls the line low.
`timescale 1ns/100ps
`default_nettype none

module smbus_register_slave
	import smbus_register_slave_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = BUS_TIMEOUT_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Register bank of the rest of the device
	output logic [7:0] reg_pointer,
	output logic reg_wr_en,
	output logic [7:0] reg_wr_data,
	output logic reg_rd_en,
	input wire logic [7:0] reg_rd_data,
	// Configuration and alert
	output logic [7:0] bus_and_monitor_config,
	output logic [7:0] pin_function_config,
	input wire logic alert_condition,
	output logic alert_n
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	bus_state_e state_q, state_d;
	logic [3:0] bit_cnt_q, bit_cnt_d;
	logic [7:0] shift_q, shift_d;
	logic [1:0] byte_idx_q, byte_idx_d;
	logic ara_q, ara_d;
	logic drive_q, drive_d;
	logic [7:0] ptr_q, ptr_d;
	logic [7:0] cfg1_q, cfg1_d;
	logic [7:0] cfg4_q, cfg4_d;
	logic wr_en_q, wr_en_d;
	logic [7:0] wr_data_q, wr_data_d;
	logic rd_en_q, rd_en_d;
	logic ara_done_q, ara_done_d;
	logic status_seen_q, status_seen_d;
	logic alert_pend_q, alert_pend_d;
	logic alert_n_q, alert_n_d;
	logic [31:0] idle_cnt_q, idle_cnt_d;
	logic scl_q, scl_p, sda_q, sda_p;

	logic scl_rise, scl_fall, start_det, stop_det, timeout;
	logic [7:0] tx_byte;

	// Own address always; alert response only for a read while alerting
	function automatic logic addr_hit(input logic [7:0] b, input logic alerting);
		addr_hit = (b[7:1] == SLAVE_ADDR)
			|| (b[7:1] == ALERT_RESP_ADDR && b[0] && alerting);
	endfunction

	// Locally held configuration shadows the external bank
	function automatic logic [7:0] read_mux(input logic [7:0] p, input logic [7:0] ext,
		input logic [7:0] c1, input logic [7:0] c4);
		if (p == BUS_AND_MONITOR_CONFIG_ADDR) begin
			read_mux = c1;
		end else if (p == PIN_FUNCTION_CONFIG_ADDR) begin
			read_mux = c4;
		end else begin
			read_mux = ext;
		end
	endfunction

	assign scl_rise = scl_q && !scl_p;
	assign scl_fall = !scl_q && scl_p;
	assign start_det = scl_q && scl_p && sda_p && !sda_q;
	assign stop_det = scl_q && scl_p && !sda_p && sda_q;
	assign timeout = (state_q != S_IDLE) && !cfg1_q[BUS_TIMEOUT_DISABLE_BIT]
		&& (idle_cnt_q >= 32'(TIMEOUT_CYCLES - 1));
	assign tx_byte = ara_q ? {SLAVE_ADDR, 1'b0} : read_mux(ptr_q, reg_rd_data, cfg1_q, cfg4_q);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		bit_cnt_d = bit_cnt_q;
		shift_d = shift_q;
		byte_idx_d = byte_idx_q;
		ara_d = ara_q;
		drive_d = drive_q;
		ptr_d = ptr_q;
		cfg1_d = cfg1_q;
		cfg4_d = cfg4_q;
		wr_en_d = 1'b0;
		wr_data_d = wr_data_q;
		rd_en_d = 1'b0;
		ara_done_d = ara_done_q;
		status_seen_d = status_seen_q;
		// Any edge on either line counts as activity
		if (state_q == S_IDLE || scl_q != scl_p || sda_q != sda_p) begin
			idle_cnt_d = 32'h0;
		end else begin
			idle_cnt_d = idle_cnt_q + 32'h1;
		end
		if (start_det) begin
			state_d = S_ADDR;
			bit_cnt_d = 4'h0;
			byte_idx_d = 2'h0;
			drive_d = 1'b0;
		end else if (stop_det || timeout) begin
			state_d = S_IDLE;
			drive_d = 1'b0;
		end else begin
			unique case (state_q)
				S_IDLE, S_WAIT: begin
				end
				S_ADDR, S_RX: begin
					if (scl_rise) begin
						shift_d = {shift_q[6:0], sda_q};
						bit_cnt_d = bit_cnt_q + 4'h1;
					end else if (scl_fall && bit_cnt_q == BITS_PER_BYTE) begin
						bit_cnt_d = 4'h0;
						if (state_q == S_ADDR) begin
							if (addr_hit(shift_q, !alert_n_q)) begin
								drive_d = 1'b1;
								state_d = S_ADDR_ACK;
								ara_d = (shift_q[7:1] == ALERT_RESP_ADDR);
								shift_d = {7'h0, shift_q[0]};
							end else begin
								state_d = S_WAIT;
							end
						end else if (byte_idx_q == 2'h0) begin
							ptr_d = shift_q;
							drive_d = 1'b1;
							state_d = S_RX_ACK;
							byte_idx_d = 2'h1;
						end else if (byte_idx_q == 2'h1) begin
							wr_en_d = 1'b1;
							wr_data_d = shift_q;
							if (ptr_q == BUS_AND_MONITOR_CONFIG_ADDR) begin
								cfg1_d = shift_q;
							end
							if (ptr_q == PIN_FUNCTION_CONFIG_ADDR) begin
								cfg4_d = shift_q;
							end
							drive_d = 1'b1;
							state_d = S_RX_ACK;
							byte_idx_d = 2'h2;
						end else begin
							// A third byte is left unacknowledged
							state_d = S_WAIT;
						end
					end
				end
				S_ADDR_ACK: begin
					if (scl_fall) begin
						if (shift_q[0]) begin
							shift_d = tx_byte;
							drive_d = !tx_byte[7];
							rd_en_d = !ara_q;
							state_d = S_TX;
						end else begin
							drive_d = 1'b0;
							state_d = S_RX;
						end
					end
				end
				S_RX_ACK: begin
					if (scl_fall) begin
						drive_d = 1'b0;
						state_d = S_RX;
					end
				end
				S_TX: begin
					if (scl_rise) begin
						bit_cnt_d = bit_cnt_q + 4'h1;
						// Released a one but the line is low: another sender wins
						if (!drive_q && !sda_q) begin
							state_d = S_WAIT;
						end
					end else if (scl_fall) begin
						if (bit_cnt_q == BITS_PER_BYTE) begin
							drive_d = 1'b0;
							state_d = S_MASTER_ACK;
						end else begin
							shift_d = {shift_q[6:0], 1'b0};
							drive_d = !shift_q[6];
						end
					end
				end
				S_MASTER_ACK: begin
					// Exactly one byte per read, whatever the master answers
					if (scl_fall) begin
						state_d = S_WAIT;
						ara_done_d = ara_done_q || ara_q;
					end
				end
			endcase
		end

		// clearing needs the answer, a status read and no condition
		if (rd_en_q && ara_done_q
			&& (ptr_q == STATUS_FIRST_ADDR || ptr_q == STATUS_SECOND_ADDR)) begin
			status_seen_d = 1'b1;
		end
		if (alert_condition) begin
			alert_pend_d = 1'b1;
		end else if (status_seen_q) begin
			alert_pend_d = 1'b0;
			status_seen_d = 1'b0;
			ara_done_d = 1'b0;
		end else begin
			alert_pend_d = alert_pend_q;
		end
		alert_n_d = !(alert_pend_q && cfg4_q[1:0] == FUNC_ALERT_OUTPUT);
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_q <= S_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			byte_idx_q <= 2'h0;
			ara_q <= 1'b0;
			drive_q <= 1'b0;
			ptr_q <= POINTER_RESET;
			cfg1_q <= BUS_AND_MONITOR_CONFIG_RESET;
			cfg4_q <= PIN_FUNCTION_CONFIG_RESET;
			wr_en_q <= 1'b0;
			wr_data_q <= 8'h00;
			rd_en_q <= 1'b0;
			ara_done_q <= 1'b0;
			status_seen_q <= 1'b0;
			alert_pend_q <= 1'b0;
			alert_n_q <= 1'b1;
			idle_cnt_q <= 32'h0;
			scl_q <= 1'b1;
			scl_p <= 1'b1;
			sda_q <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			state_q <= state_d;
			bit_cnt_q <= bit_cnt_d;
			shift_q <= shift_d;
			byte_idx_q <= byte_idx_d;
			ara_q <= ara_d;
			drive_q <= drive_d;
			ptr_q <= ptr_d;
			cfg1_q <= cfg1_d;
			cfg4_q <= cfg4_d;
			wr_en_q <= wr_en_d;
			wr_data_q <= wr_data_d;
			rd_en_q <= rd_en_d;
			ara_done_q <= ara_done_d;
			status_seen_q <= status_seen_d;
			alert_pend_q <= alert_pend_d;
			alert_n_q <= alert_n_d;
			idle_cnt_q <= idle_cnt_d;
			scl_q <= scl_in;
			scl_p <= scl_q;
			sda_q <= sda_in;
			sda_p <= sda_q;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = drive_q;
	assign reg_pointer = ptr_q;
	assign reg_wr_en = wr_en_q;
	assign reg_wr_data = wr_data_q;
	assign reg_rd_en = rd_en_q;
	assign bus_and_monitor_config = cfg1_q;
	assign pin_function_config = cfg4_q;
	assign alert_n = alert_n_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_addr_ack_match: assert property (@(posedge clock) disable iff (!rst_n)
		(state_q == S_ADDR && state_d == S_ADDR_ACK) |->
		(shift_q[7:1] == SLAVE_ADDR || (shift_q[7:1] == ALERT_RESP_ADDR && !alert_n_q)))
		else $error("address acknowledged that is not ours");

	a_start_restarts: assert property (@(posedge clock) disable iff (!rst_n)
		start_det |=> state_q == S_ADDR && bit_cnt_q == 4'h0 && !drive_q)
		else $error("start did not begin a new operation");

	a_stop_idles: assert property (@(posedge clock) disable iff (!rst_n)
		stop_det |=> state_q == S_IDLE && !drive_q)
		else $error("stop did not end the operation");

	a_data_on_low: assert property (@(posedge clock) disable iff (!rst_n)
		$changed(drive_q) |-> !$past(scl_q) || state_q == S_IDLE || state_q == S_ADDR)
		else $error("data line moved while clock high");

	a_pointer_first: assert property (@(posedge clock) disable iff (!rst_n)
		$changed(ptr_q) |-> $past(state_q) == S_RX && $past(byte_idx_q) == 2'h0)
		else $error("pointer loaded from other than the first byte");

	a_write_second: assert property (@(posedge clock) disable iff (!rst_n)
		wr_en_q |-> $past(byte_idx_q) == 2'h1 && reg_wr_data == $past(shift_q))
		else $error("data write not from the second byte");

	a_timeout_release: assert property (@(posedge clock) disable iff (!rst_n)
		timeout && !start_det |=> state_q == S_IDLE && !drive_q)
		else $error("timeout did not release the bus");

	a_alert_pin_use: assert property (@(posedge clock) disable iff (!rst_n)
		!alert_n_q |-> $past(cfg4_q[1:0]) == FUNC_ALERT_OUTPUT && $past(alert_pend_q))
		else $error("alert driven outside alert pin use");

	a_alert_hold: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(alert_pend_q) |-> $past(status_seen_q) && !$past(alert_condition))
		else $error("alert released before status read");

	a_one_read_byte: assert property (@(posedge clock) disable iff (!rst_n)
		(state_q == S_MASTER_ACK && scl_fall && !start_det && !stop_det && !timeout)
		|=> state_q == S_WAIT && !drive_q)
		else $error("more than one byte supplied in a read");

endmodule // smbus_register_slave

`default_nettype wire

// file: smbus_register_slave_pkg.sv
// Purpose: Constants and types for the serial management bus register slave.
// Assumes: 100 MHz system clock; bus pins sampled synchronously.
// Notes: Summary of operation follows.
//
// Summary of operation
// - Answer slave address 0x2e, and 0x0c for a read while alerting; the read/write bit is the address byte LSB.
// - Each byte is eight data bits MSB first, then one receiver acknowledge.
// - Data changes only with clock low; data rise with clock high means stop.
// - Direction is fixed at start; switching needs a new start.
// - Accept one or two write bytes; supply exactly one byte per read.
// - First write byte after the address always loads the pointer.
// - Second write byte goes to the register the pointer selects.
// - Reads return the pointed register without rewriting the pointer.
// - Repeated start right after a pointer write may begin a read.
// - Repeated start in place of stop begins a new operation.
// - Write byte: acknowledge address, command code, then the data byte.
// - Receive byte: acknowledge read address, drive one byte, expect nack and stop.
// - While alert is low, answer alert response address with own address.
// - Take part in arbitration during alert response; lowest address wins.
// - Release alert only after status is read and the condition is gone.
// - With timeout enabled, 35 ms without activity releases data and abandons transfer.
// - Bit 6 of register 0x40 disables the timeout; default zero, enabled.
// - Bits 1:0 of 0x7d choose pin use: tach, alert, thermal, GPIO.

package smbus_register_slave_pkg;

	// ---------------------------------------------------------------
	// Addresses and register map
	// ---------------------------------------------------------------
	localparam logic [6:0] SLAVE_ADDR = 7'h2e;
	localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
	localparam logic [7:0] BUS_AND_MONITOR_CONFIG_ADDR = 8'h40;
	localparam logic [7:0] PIN_FUNCTION_CONFIG_ADDR = 8'h7d;
	localparam logic [7:0] STATUS_FIRST_ADDR = 8'h41;
	localparam logic [7:0] STATUS_SECOND_ADDR = 8'h42;

	// ---------------------------------------------------------------
	// Reset values and fields
	// ---------------------------------------------------------------
	localparam logic [7:0] BUS_AND_MONITOR_CONFIG_RESET = 8'h00;
	localparam logic [7:0] PIN_FUNCTION_CONFIG_RESET = 8'h00;
	localparam logic [7:0] POINTER_RESET = 8'h00;
	localparam int BUS_TIMEOUT_DISABLE_BIT = 6;

	// Pin use codes as {bit1, bit0}
	localparam logic [1:0] FUNC_FOURTH_TACH_INPUT = 2'h0;
	localparam logic [1:0] FUNC_ALERT_OUTPUT = 2'h1;
	localparam logic [1:0] FUNC_THERMAL_LIMIT_PIN = 2'h2;
	localparam logic [1:0] FUNC_GPIO = 2'h3;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam int CLOCK_KHZ = 100000;
	localparam int BUS_TIMEOUT_MS = 35;
	localparam int BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_MS * CLOCK_KHZ;

	typedef enum logic [2:0] {
		S_IDLE,
		S_ADDR,
		S_ADDR_ACK,
		S_RX,
		S_RX_ACK,
		S_TX,
		S_MASTER_ACK,
		S_WAIT
	} bus_state_e;

endpackage

// file: smbus_master_model.sv
// Purpose: Host-side bus master model driving the serial clock and data.
// Assumes: Data line has a pull-up; the wired level is resolved outside.
// Notes: hp is clocks per bit phase, 3 or more; the bench varies it.
`timescale 1ns/100ps
`default_nettype none

module smbus_master_model (
	// Clock
	input wire logic clock,
	// Bus
	input wire logic sda_line,
	output logic scl,
	output logic sda_rel
);
	int hp;

	initial begin
		hp = 4;
		scl = 1'b1;
		sda_rel = 1'b1;
	end

	task automatic gap(input int n);
		repeat (n) @(negedge clock);
	endtask

	// Also serves as repeated start in place of a stop
	task automatic start();
		gap(hp);
		sda_rel = 1'b1;
		gap(hp);
		scl = 1'b1;
		gap(hp);
		sda_rel = 1'b0;
		gap(hp);
		scl = 1'b0;
	endtask

	task automatic stop();
		gap(hp);
		sda_rel = 1'b0;
		gap(hp);
		scl = 1'b1;
		gap(hp);
		sda_rel = 1'b1;
		gap(hp);
	endtask

	// Data moves only mid-low; sampled at the end of the high phase
	task automatic bitx(input logic b, output logic r);
		gap(hp);
		sda_rel = b;
		gap(hp);
		scl = 1'b1;
		gap(hp);
		r = sda_line;
		scl = 1'b0;
	endtask

	task automatic send8(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
		end
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		send8(d);
		bitx(1'b1, r);
		ack = ~r;
	endtask

	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(nack, r);
	endtask
endmodule // smbus_master_model

`default_nettype wire

// file: tb.sv
// Purpose: Self-checking bench for the bus register slave.
// Assumes: Master model and a byte-wide register bank surround the slave.
// Notes: Timeout shortened to 200 clocks to keep stall cases short.
`timescale 1ns/100ps
`default_nettype none

module tb
	import smbus_register_slave_pkg::*;
;
	localparam int unsigned TO = 200;
	localparam logic [7:0] BAD [4] = '{{SLAVE_ADDR ^ 7'h01, 1'b0}, {ALERT_RESP_ADDR, 1'b0},
		{ALERT_RESP_ADDR, 1'b1}, {SLAVE_ADDR ^ 7'h40, 1'b0}};
	logic clock, rst_n, alert_condition, ack;
	logic scl, sda_rel, sda_out, sda_oe, reg_wr_en, reg_rd_en, alert_n;
	logic [7:0] reg_pointer, reg_wr_data, bmc, pfc, a8, d8;
	logic [7:0] mem [256];
	logic [7:0] gold [256];
	int miscompares, n_tests;
	int n_rd = 0;
	wire logic sda_line = sda_rel & ~(sda_oe & ~sda_out);
	wire logic [7:0] rd_data = mem[reg_pointer];

	smbus_register_slave #(.TIMEOUT_CYCLES(TO)) dut (.clock(clock), .rst_n(rst_n),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
		.reg_pointer(reg_pointer), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
		.reg_rd_en(reg_rd_en), .reg_rd_data(rd_data), .bus_and_monitor_config(bmc),
		.pin_function_config(pfc), .alert_condition(alert_condition), .alert_n(alert_n));
	smbus_master_model m (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock) if (reg_wr_en === 1'b1) mem[reg_pointer] <= reg_wr_data;

	// Register fetches, one per read byte other than an alert response
	always @(posedge clock) begin
		if (reg_rd_en === 1'b1) begin
			n_rd <= n_rd + 1;
		end
	end

	// Alert pin is low only in alert pin use with an alert pending
	function automatic logic exp_alert_n(input logic [1:0] pin_use, input logic pend);
		return !(pend && pin_use == FUNC_ALERT_OUTPUT);
	endfunction

	task automatic chk1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t bit %b want %b", $time, got, exp);
		end
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t byte %h want %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		if (miscompares == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic addr(input logic [7:0] b, input logic want);
		m.wbyte(b, ack);
		chk1(ack, want);
	endtask

	task automatic wreg(input logic [7:0] p, input logic [7:0] d);
		m.start();
		addr({SLAVE_ADDR, 1'b0}, 1'b1);
		addr(p, 1'b1);
		addr(d, 1'b1);
		m.stop();
		gold[p] = d;
		chk8(reg_pointer, p);
		chk8(mem[p], d);
	endtask

	task automatic rreg(input logic [7:0] p, input logic set_ptr);
		int n0;
		n0 = n_rd;
		m.start();
		if (set_ptr) begin
			addr({SLAVE_ADDR, 1'b0}, 1'b1);
			addr(p, 1'b1);
			m.start();
		end
		addr({SLAVE_ADDR, 1'b1}, 1'b1);
		m.rbyte(1'b1, d8);
		m.stop();
		chk8(d8, gold[p]);
		chk8(8'(n_rd - n0), 8'h01);
	endtask

	// Stall with the clock low while the address is being acknowledged
	task automatic stall(input logic want_oe);
		m.start();
		m.send8({SLAVE_ADDR, 1'b0});
		m.gap(5);
		chk1(sda_oe, 1'b1);
		m.gap(TO + 20);
		chk1(sda_oe, want_oe);
		m.bitx(1'b1, ack);
		m.stop();
	endtask

	initial begin
		repeat (100000) @(posedge clock);
		miscompares++;
		$display("CHECK FAILED %0t run too long", $time);
		test_done();
	end

	initial begin
		rst_n = 1'b0;
		alert_condition = 1'b0;
		miscompares = 0;
		n_tests = 0;
		void'($urandom(43394));
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'($urandom);
			gold[i] = mem[i];
		end
		gold[8'h40] = 8'h00;
		gold[8'h7d] = 8'h00;
		repeat (5) @(negedge clock);
		rst_n = 1'b1;
		m.gap(2);
		chk8(bmc, 8'h00);
		chk8(pfc, 8'h00);
		chk8(reg_pointer, 8'h00);
		chk1(alert_n, 1'b1);
		for (int i = 0; i < 8; i++) begin
			m.hp = 3 + int'($urandom % 4);
			a8 = 8'($urandom) & 8'h3f;
			wreg(a8, 8'($urandom));
			rreg(a8, 1'b1);
			rreg(a8, 1'b0);
		end
		m.start();
		addr({SLAVE_ADDR, 1'b0}, 1'b1);
		addr(8'h10, 1'b1);
		addr(8'h5a, 1'b1);
		addr(8'ha5, 1'b0);
		m.stop();
		gold[8'h10] = 8'h5a;
		rreg(8'h10, 1'b1);
		foreach (BAD[i]) begin
			m.start();
			addr(BAD[i], 1'b0);
			m.stop();
		end
		alert_condition = 1'b1;
		for (int f = 0; f < 4; f++) begin
			wreg(PIN_FUNCTION_CONFIG_ADDR, 8'(f));
			chk8(pfc, 8'(f));
			chk1(alert_n, exp_alert_n(2'(f), 1'b1));
		end
		alert_condition = 1'b0;
		wreg(PIN_FUNCTION_CONFIG_ADDR, 8'h01);
		chk1(alert_n, 1'b0);
		// A lower-addressed alerting device pulls bit 6 low and must win
		a8 = {7'h1a, 1'b0};
		m.start();
		addr({ALERT_RESP_ADDR, 1'b1}, 1'b1);
		for (int i = 7; i >= 0; i--) begin
			m.bitx(a8[i], ack);
			d8[i] = ack;
		end
		m.bitx(1'b1, ack);
		m.stop();
		chk8(d8, a8);
		chk1(alert_n, 1'b0);
		m.start();
		addr({ALERT_RESP_ADDR, 1'b1}, 1'b1);
		m.rbyte(1'b1, d8);
		m.stop();
		chk8(d8, {SLAVE_ADDR, 1'b0});
		chk1(alert_n, 1'b0);
		rreg(8'h41, 1'b1);
		m.gap(3);
		chk1(alert_n, 1'b1);
		stall(1'b0);
		wreg(BUS_AND_MONITOR_CONFIG_ADDR, 8'h40);
		chk8(bmc, 8'h40);
		stall(1'b1);
		rreg(BUS_AND_MONITOR_CONFIG_ADDR, 1'b1);
		test_done();
	end
endmodule // tb

`default_nettype wire
